// *** inc/timer2_ctrl_pkg.sv ***
// Constants for the timer-2 flag, asynchronous clock and prescaler control block.
// Overview of operation
// [R1] Compare-B match sets flag bit 2 of the event flag register.
// [R2] Compare-A match sets flag bit 1 of the event flag register.
// [R3] Overflow sets flag bit 0; in phase-correct PWM, direction reversal at zero.
// [R4] Flags clear on vector execution or on writing one; zero leaves them.
// [R5] Interrupt requested only when flag, its enable and global enable are set.
// [R6] External clock select enables input buffer when async; crystal runs only when zero.
// [R7] Software sets external clock select before enabling asynchronous operation.
// [R8] Async select bit 5 picks the I/O clock or the timer oscillator.
// [R9] After changing async select, software rewrites counter, compares and controls.
// [R10] Async writes to five registers set busy bits 4..0 until transferred.
// [R11] Software must not write a register while its busy bit is set.
// [R12] Sync hold mode bit 7 keeps both prescaler reset bits as written.
// [R13] Clearing sync hold mode clears both prescaler reset bits together.
// [R14] Async prescaler reset self-clears, waits in async mode, holds in sync mode.
// [R15] Shared prescaler reset resets both other timers, self-clears unless sync mode.
// [R16] Low I/O registers answer at data offset and at offset minus 0x20.
// [R17] Unimplemented bits of flag, status and control registers read zero.
package timer2_ctrl_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] EVENT_FLAGS_ADDR = 8'h37;
  localparam logic [7:0] SYNC_CTRL_ADDR = 8'h43;
  localparam logic [7:0] ASYNC_STATUS_ADDR = 8'hb6;
  localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
  localparam logic [7:0] IO_SPACE_LIMIT = 8'h60;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int COMPARE_B_BIT = 2;
  localparam int COMPARE_A_BIT = 1;
  localparam int OVERFLOW_BIT = 0;
  localparam int EXT_CLOCK_BIT = 6;
  localparam int ASYNC_SEL_BIT = 5;
  localparam int SYNC_HOLD_BIT = 7;
  localparam int ASYNC_PSR_BIT = 1;
  localparam int SHARED_PSR_BIT = 0;
  localparam int NUM_FLAGS = 3;
  localparam int NUM_BUSY = 5;
  localparam logic [7:0] FLAG_MASK = 8'h07;
  localparam logic [7:0] SYNC_CTRL_MASK = 8'h83;
  // Pin input synchroniser depth.
  localparam int SYNC_STAGES = 3;
endpackage

// *** hw/update_busy_tracker.sv ***
// Busy flag for one register that is written across into the timer clock domain.
`timescale 1ns/1ps
module update_busy_tracker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic async_mode,
  input wire logic reg_write,
  input wire logic transfer_done,
  output logic busy
);
  logic busy_q;
  logic busy_d;

  always_comb begin
    busy_d = busy_q;
    if (transfer_done) begin
      busy_d = 1'b0;
    end
    // [R10] Set on async write.
    if (reg_write && async_mode) begin
      busy_d = 1'b1;
    end
    if (!async_mode) begin
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;
endmodule

// *** hw/timer2_flags_async_prescaler_ctrl.sv ***
// Event flags, asynchronous clock status and prescaler control of timer 2.
`timescale 1ns/1ps
module timer2_flags_async_prescaler_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] bus_addr,
  input wire logic io_space,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [7:0] bus_rdata,
  input wire logic compare_a_match,
  input wire logic compare_b_match,
  input wire logic counter_overflow,
  input wire logic bottom_reversal,
  input wire logic phase_correct_mode,
  input wire logic [2:0] irq_enable,
  input wire logic global_irq_enable,
  input wire logic [2:0] vector_ack,
  output logic [2:0] irq_request,
  input wire logic [4:0] async_reg_write,
  input wire logic [4:0] async_transfer_done_pin,
  input wire logic async_psr_done_pin,
  output logic ext_clock_buffer_en,
  output logic crystal_osc_en,
  output logic timer_clock_sel,
  output logic async_prescaler_rst,
  output logic shared_prescaler_rst
);
  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  logic [7:0] eff_addr;
  logic sel_flags;
  logic sel_sync;
  logic sel_async;

  // [R16] I/O space alias.
  always_comb begin
    eff_addr = bus_addr;
    if (io_space) begin
      eff_addr = bus_addr + timer2_ctrl_pkg::IO_SPACE_OFFSET;
    end
    sel_flags = (eff_addr == timer2_ctrl_pkg::EVENT_FLAGS_ADDR);
    sel_sync = (eff_addr == timer2_ctrl_pkg::SYNC_CTRL_ADDR);
    sel_async = (eff_addr == timer2_ctrl_pkg::ASYNC_STATUS_ADDR) && !io_space;
  end

  // ---------------------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_s3_q;
  logic [5:0] pin_st_q;
  logic [5:0] pin_st_d;
  logic [5:0] pin_rise;

  assign pin_raw = {async_psr_done_pin, async_transfer_done_pin};

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pin
      always_comb begin
        pin_st_d[g] = pin_st_q[g];
        if (pin_s2_q[g] == pin_s3_q[g]) begin
          pin_st_d[g] = pin_s2_q[g];
        end
      end
      assign pin_rise[g] = pin_st_d[g] && !pin_st_q[g];
    end
  endgenerate

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      pin_s3_q <= 6'h00;
      pin_st_q <= 6'h00;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_st_q <= pin_st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------------------
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  always_comb begin
    flag_set = 3'h0;
    // [R1] Compare B match.
    flag_set[timer2_ctrl_pkg::COMPARE_B_BIT] = compare_b_match;
    // [R2] Compare A match.
    flag_set[timer2_ctrl_pkg::COMPARE_A_BIT] = compare_a_match;
    // [R3] Overflow or bottom reversal.
    flag_set[timer2_ctrl_pkg::OVERFLOW_BIT] = phase_correct_mode ? bottom_reversal : counter_overflow;
    // [R4] Ack or write one clears.
    flag_clr = vector_ack;
    if (bus_write && sel_flags) begin
      flag_clr = flag_clr | bus_wdata[2:0];
    end
    flags_d = (flags_q & ~flag_clr) | flag_set;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // [R5] Request gating.
  assign irq_request = flags_q & irq_enable & {3{global_irq_enable}};

  // ---------------------------------------------------------------------------
  // Asynchronous clock status
  // ---------------------------------------------------------------------------
  logic ext_clk_q;
  logic ext_clk_d;
  logic async_sel_q;
  logic async_sel_d;
  logic [4:0] busy;

  always_comb begin
    ext_clk_d = ext_clk_q;
    async_sel_d = async_sel_q;
    if (bus_write && sel_async) begin
      ext_clk_d = bus_wdata[timer2_ctrl_pkg::EXT_CLOCK_BIT];
      async_sel_d = bus_wdata[timer2_ctrl_pkg::ASYNC_SEL_BIT];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ext_clk_q <= 1'b0;
      async_sel_q <= 1'b0;
    end else begin
      ext_clk_q <= ext_clk_d;
      async_sel_q <= async_sel_d;
    end
  end

  // [R6] Clock buffer and crystal.
  assign ext_clock_buffer_en = ext_clk_q && async_sel_q;
  assign crystal_osc_en = async_sel_q && !ext_clk_q;
  // [R8] Timer clock select.
  assign timer_clock_sel = async_sel_q;

  generate
    for (g = 0; g < timer2_ctrl_pkg::NUM_BUSY; g++) begin : g_busy
      update_busy_tracker u_busy (
        .mclk(mclk),
        .nrst(nrst),
        .async_mode(async_sel_q),
        .reg_write(async_reg_write[g]),
        .transfer_done(pin_rise[g]),
        .busy(busy[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Prescaler reset and synchronisation control
  // ---------------------------------------------------------------------------
  logic hold_q;
  logic hold_d;
  logic apsr_q;
  logic apsr_d;
  logic spsr_q;
  logic spsr_d;

  always_comb begin
    hold_d = hold_q;
    apsr_d = apsr_q;
    spsr_d = spsr_q;
    // [R14] Async reset waits.
    if (apsr_q && (!async_sel_q || pin_rise[5])) begin
      apsr_d = 1'b0;
    end
    // [R15] Shared reset self-clears.
    spsr_d = 1'b0;
    if (bus_write && sel_sync) begin
      hold_d = bus_wdata[timer2_ctrl_pkg::SYNC_HOLD_BIT];
      apsr_d = apsr_d | bus_wdata[timer2_ctrl_pkg::ASYNC_PSR_BIT];
      spsr_d = bus_wdata[timer2_ctrl_pkg::SHARED_PSR_BIT];
      // [R12] Hold written values.
      if (bus_wdata[timer2_ctrl_pkg::SYNC_HOLD_BIT]) begin
        apsr_d = bus_wdata[timer2_ctrl_pkg::ASYNC_PSR_BIT];
      end
    end else if (hold_q) begin
      apsr_d = apsr_q;
      spsr_d = spsr_q;
    end
    // [R13] Release both together.
    if (!hold_d) begin
      spsr_d = spsr_d && !hold_q && bus_write && sel_sync;
      if (hold_q) begin
        apsr_d = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= 1'b0;
      apsr_q <= 1'b0;
      spsr_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      apsr_q <= apsr_d;
      spsr_q <= spsr_d;
    end
  end

  assign async_prescaler_rst = apsr_q;
  assign shared_prescaler_rst = spsr_q;

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // [R17] Unused bits read zero.
  always_comb begin
    rdata_d = 8'h00;
    if (bus_read && sel_flags) begin
      rdata_d = {5'h00, flags_q};
    end else if (bus_read && sel_sync) begin
      rdata_d = {hold_q, 5'h00, apsr_q, spsr_q};
    end else if (bus_read && sel_async) begin
      rdata_d = {1'b0, ext_clk_q, async_sel_q, busy};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;
endmodule

// *** tb/timer2_ctrl_checker.sv ***
// Checker for the timer-2 flag, clock-select and prescaler control outputs.
`timescale 1ns/1ps
module timer2_ctrl_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] bus_addr,
  input wire logic io_space,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_write,
  input wire logic compare_a_match,
  input wire logic compare_b_match,
  input wire logic counter_overflow,
  input wire logic phase_correct_mode,
  input wire logic [2:0] irq_enable,
  input wire logic global_irq_enable,
  input wire logic [2:0] vector_ack,
  input wire logic [2:0] irq_request,
  input wire logic ext_clock_buffer_en,
  input wire logic crystal_osc_en,
  input wire logic timer_clock_sel,
  input wire logic async_prescaler_rst,
  input wire logic shared_prescaler_rst
);
  logic wr_gc;
  assign wr_gc = bus_write && (io_space ? bus_addr == 8'h23 : bus_addr == 8'h43);
  // Mirror of the hold bit, so that releases can be told from plain writes.
  logic hold_mirror_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_mirror_q <= 1'h0;
    end else if (wr_gc) begin
      hold_mirror_q <= bus_wdata[7];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  irq_gate_a: assert property (irq_request == (irq_request & irq_enable & {3{global_irq_enable}}))
    else $error("interrupt request without its enables");
  cmp_a_irq_a: assert property (compare_a_match ##1 (irq_enable[1] && global_irq_enable) |-> irq_request[1])
    else $error("compare A match gave no request");
  cmp_b_irq_a: assert property (compare_b_match ##1 (irq_enable[2] && global_irq_enable) |-> irq_request[2])
    else $error("compare B match gave no request");
  ack_clear_a: assert property (vector_ack[1] && !compare_a_match |=> !irq_request[1])
    else $error("vector execution left the compare A request");
  ovf_irq_a: assert property (counter_overflow && !phase_correct_mode ##1 (irq_enable[0] && global_irq_enable)
    |-> irq_request[0])
    else $error("overflow gave no request");
  clk_sel_a: assert property (crystal_osc_en |-> timer_clock_sel && !ext_clock_buffer_en)
    else $error("crystal runs with external clock selected");
  psr_pulse_a: assert property (wr_gc && bus_wdata == 8'h03 && !timer_clock_sel && !hold_mirror_q
    |=> (async_prescaler_rst && shared_prescaler_rst) ##1 !(async_prescaler_rst || shared_prescaler_rst))
    else $error("prescaler reset did not pulse once");
  hold_keep_a: assert property ((wr_gc && bus_wdata == 8'h83) ##1 !bus_write
    |-> (async_prescaler_rst && shared_prescaler_rst) [*2])
    else $error("held prescaler reset dropped");
  hold_release_a: assert property (wr_gc && bus_wdata == 8'h00 && hold_mirror_q
    |=> !(async_prescaler_rst || shared_prescaler_rst))
    else $error("prescaler reset stayed after release");
  async_wait_a: assert property (wr_gc && bus_wdata == 8'h02 && timer_clock_sel && !hold_mirror_q
    |=> async_prescaler_rst [*2])
    else $error("async prescaler reset cleared too early");
endmodule
bind timer2_flags_async_prescaler_ctrl timer2_ctrl_checker u_chk (.*);

// *** tb/timer2_flags_async_prescaler_ctrl_test.sv ***
// Self-checking bench for the timer-2 flag and prescaler control block.
`timescale 1ns/1ps
module timer2_flags_async_prescaler_ctrl_test;
  typedef struct packed {logic [4:0] ev; logic [7:0] fl;} row_t;
  logic mclk = 1'h0, nrst = 1'h0, io_space = 1'h0, bus_write = 1'h0, bus_read = 1'h0;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, outs;
  logic compare_a_match = 1'h0, compare_b_match = 1'h0, counter_overflow = 1'h0, bottom_reversal = 1'h0;
  logic phase_correct_mode = 1'h0, global_irq_enable = 1'h0, async_psr_done_pin = 1'h0;
  logic [2:0] irq_enable = 3'h0, vector_ack = 3'h0, irq_request;
  logic [4:0] async_reg_write = 5'h00, async_transfer_done_pin = 5'h00;
  logic ext_clock_buffer_en, crystal_osc_en, timer_clock_sel, async_prescaler_rst, shared_prescaler_rst;
  int n_fail = 0, total_checks = 0, cycles = 0;
  row_t rows [6] = '{'{5'h08, 8'h04}, '{5'h04, 8'h02}, '{5'h02, 8'h01}, '{5'h01, 8'h00}, '{5'h12, 8'h00},
    '{5'h11, 8'h01}};
  assign outs = {3'h0, ext_clock_buffer_en, crystal_osc_en, timer_clock_sel, async_prescaler_rst, shared_prescaler_rst};
  timer2_flags_async_prescaler_ctrl u_dut (.*);
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
    @(negedge mclk);
    bus_addr = a;
    io_space = io;
    bus_wdata = d;
    bus_write = 1'h1;
    @(negedge mclk);
    bus_write = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] e);
    @(negedge mclk);
    bus_addr = a;
    io_space = io;
    bus_read = 1'h1;
    @(negedge mclk);
    bus_read = 1'h0;
    chk(bus_rdata, e);
  endtask
  task automatic ev(input logic [4:0] e);
    @(negedge mclk);
    {phase_correct_mode, compare_b_match, compare_a_match, counter_overflow, bottom_reversal} = e;
    @(negedge mclk);
    {compare_b_match, compare_a_match, counter_overflow, bottom_reversal} = 4'h0;
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    nrst = 1'h1;
    rd(8'h37, 1'h0, 8'h00);
    rd(8'h43, 1'h0, 8'h00);
    rd(8'hb6, 1'h0, 8'h00);
    rd(8'h50, 1'h0, 8'h00);
    foreach (rows[i]) begin
      ev(rows[i].ev);
      rd(8'h37, 1'h0, rows[i].fl);
      wr(8'h17, 1'h1, 8'h07);
    end
    rd(8'h17, 1'h1, 8'h00);
    ev(5'h0e);
    wr(8'h37, 1'h0, 8'hfa);
    rd(8'h37, 1'h0, 8'h05);
    irq_enable = 3'h7;
    #1 chk({5'h00, irq_request}, 8'h00);
    global_irq_enable = 1'h1;
    #1 chk({5'h00, irq_request}, 8'h05);
    ev(5'h0e);
    chk({5'h00, irq_request}, 8'h07);
    vector_ack = 3'h6;
    @(negedge mclk);
    vector_ack = 3'h0;
    #1 chk({5'h00, irq_request}, 8'h01);
    wr(8'hb6, 1'h0, 8'h40);
    chk(outs, 8'h00);
    wr(8'hb6, 1'h0, 8'h60);
    chk(outs, 8'h14);
    wr(8'hb6, 1'h0, 8'h20);
    chk(outs, 8'h0c);
    rd(8'h96, 1'h1, 8'h00);
    async_reg_write = 5'h1f;
    @(negedge mclk);
    async_reg_write = 5'h00;
    rd(8'hb6, 1'h0, 8'h3f);
    async_transfer_done_pin = 5'h10;
    repeat (6) @(negedge mclk);
    rd(8'hb6, 1'h0, 8'h2f);
    wr(8'h43, 1'h0, 8'h02);
    repeat (2) @(negedge mclk);
    chk(outs, 8'h0e);
    async_psr_done_pin = 1'h1;
    repeat (6) @(negedge mclk);
    chk(outs, 8'h0c);
    wr(8'hb6, 1'h0, 8'h00);
    rd(8'hb6, 1'h0, 8'h00);
    wr(8'h23, 1'h1, 8'h83);
    rd(8'h43, 1'h0, 8'h83);
    chk(outs, 8'h03);
    wr(8'h43, 1'h0, 8'h00);
    chk(outs, 8'h00);
    wr(8'h43, 1'h0, 8'h03);
    rd(8'h23, 1'h1, 8'h00);
    ev(5'h0e);
    wr(8'h43, 1'h0, 8'h83);
    nrst = 1'h0;
    #1 chk({5'h00, irq_request}, 8'h00);
    chk(outs, 8'h00);
    @(negedge mclk);
    nrst = 1'h1;
    rd(8'h43, 1'h0, 8'h00);
    rd(8'h37, 1'h0, 8'h00);
    summarize();
  end
endmodule
